// [logic/two_wire_bus_control_status.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps

// Contract
// - sda and scl are sampled at the prescaled rate, not every cpu clock
// - each scl period lasts divider plus six cpu clocks
// - five-bit code maps to divider table, 22 up to 4352
// - other control bits cannot be set unless enable is already set
// - enable clear holds interface in reset, registers stay accessible
// - slave enabled mid-transfer waits for next start
// - master enabled mid-transfer may collide and resolve by arbitration
// - interrupt request is pending flag and interrupt enable
// - master select rise drives start, fall drives stop, resets to zero
// - clear then set of master select gives repeated start
// - direction bit one is transmit, zero is receive
// - master receive drives ack on ninth clock unless ack disabled
// - control bits 2..0 and status bit 3 read zero
// - transfer complete is one when done, zero while busy, resets one
// - address match sets addressed flag and interrupt; control write clears it
// - bus busy sets on start and clears on stop from any master
// - arbitration lost set by hardware, held until software clears it
// - status always readable; only bits 4 and 1 clearable by software
// - address match latches read/write bit into slave read flag
// - pending sets on ninth falling edge, slave address match, arbitration loss
// - received ack bit samples sda at ninth clock after transmit
// - lost arbitration releases sda, goes slave receive, no stop
// - transfer complete clears on data read in receive, write in transmit
// - address compare uses seven upper bits of own address register
module two_wire_bus_control_status
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // open-drain bus pins; enable low means pulling the line low
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // interrupt request to the cpu
    output logic irq
);

    twi_pkg::state_t s;
    twi_pkg::state_t next_s;
    twi_pkg::pins_t bus;

    logic enabled;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic wr_go;
    logic rd_go;
    logic [4:0] rd_index;
    logic [12:0] table_div;

    ////////////////////////////////////////////////////////////////
    // divider table: base of each group of eight, quadrupled per group
    // divider table
    always_comb
    begin
        case (s.rate[2:0])
            3'h0: table_div = 13'h0016;
            3'h1: table_div = 13'h0018;
            3'h2: table_div = 13'h001c;
            3'h3: table_div = 13'h0022;
            3'h4: table_div = 13'h002c;
            3'h5: table_div = 13'h0030;
            3'h6: table_div = 13'h0038;
            default: table_div = 13'h0044;
        endcase
        table_div = 13'(table_div << (2 * s.rate[4:3]));
    end

    // synchronised pins and edges read only the second stage
    assign bus.scl = s.scl_sync[1];
    assign bus.sda = s.sda_sync[1];
    assign enabled = s.control[twi_pkg::ctl_interface_enable];
    assign scl_rise = s.sample & bus.scl & ~s.scl_prev;
    assign scl_fall = s.sample & ~bus.scl & s.scl_prev;
    assign start_seen = s.sample & bus.scl & s.scl_prev & s.sda_prev & ~bus.sda;
    assign stop_seen = s.sample & bus.scl & s.scl_prev & ~s.sda_prev & bus.sda;
    assign wr_go = s.aw_held & s.w_held & ~s.bvalid;
    assign rd_go = arvalid & ~s.rvalid;
    assign rd_index = araddr[6:2];

    ////////////////////////////////////////////////////////////////
    // all next-state logic
    always_comb
    begin
        logic [7:0] wv;
        logic [7:0] rv;
        logic tx;
        logic master_rise;
        logic master_fall;
        logic byte_done;
        wv = s.w_data;
        rv = 8'h00;
        master_rise = 1'b0;
        master_fall = 1'b0;
        byte_done = 1'b0;
        next_s = s;
        tx = s.control[twi_pkg::ctl_direction_transmit];

        next_s.scl_sync = {s.scl_sync[0], scl_in};
        next_s.sda_sync = {s.sda_sync[0], sda_in};

        next_s.sample = 1'b0;
        if (s.sample)
        begin
            // edges compare one sample against the previous sample, never a mid-interval value
            next_s.scl_prev = bus.scl;
            next_s.sda_prev = bus.sda;
            // select edge stays visible until the engine steps
            next_s.master_prev = s.control[twi_pkg::ctl_master_select];
        end
        if (s.tick_count == 13'h0000)
        begin
            next_s.sample = 1'b1;
            // six clocks overhead, half each phase
            next_s.tick_count = 13'(((table_div + twi_pkg::sample_overhead) >> 1) - 13'h0001);
        end
        else
        begin
            next_s.tick_count = s.tick_count - 13'h0001;
        end

        if (start_seen)
            next_s.status[twi_pkg::st_bus_busy_flag] = 1'b1;
        else if (stop_seen)
            next_s.status[twi_pkg::st_bus_busy_flag] = 1'b0;

        master_rise = s.control[twi_pkg::ctl_master_select] & ~s.master_prev;
        master_fall = ~s.control[twi_pkg::ctl_master_select] & s.master_prev;

        // bit engine, stepped on sample ticks
        if (s.sample)
        begin
            case (s.engine)
                twi_pkg::st_idle:
                begin
                    // no busy check on master start
                    if (master_rise)
                    begin
                        next_s.engine = twi_pkg::st_start;
                        next_s.drive_sda_low = 1'b1;
                        next_s.master_active = 1'b1;
                    end
                end
                twi_pkg::st_start:
                begin
                    next_s.drive_scl_low = 1'b1;
                    next_s.bit_count = 4'h0;
                    next_s.shift = s.data_out;
                    next_s.engine = tx ? twi_pkg::st_wait : twi_pkg::st_low;
                    // receive byte is in flight at once
                    if (!tx)
                        next_s.status[twi_pkg::st_transfer_complete] = 1'b0;
                end
                twi_pkg::st_wait:
                begin
                    // repeated start when select rises again
                    if (master_rise)
                    begin
                        next_s.drive_sda_low = 1'b0;
                        next_s.drive_scl_low = 1'b0;
                        next_s.engine = twi_pkg::st_rstrt;
                    end
                    else if (master_fall)
                    begin
                        next_s.drive_sda_low = 1'b1;
                        next_s.drive_scl_low = 1'b0;
                        next_s.engine = twi_pkg::st_stop;
                    end
                    else if (~s.status[twi_pkg::st_transfer_complete])
                    begin
                        next_s.shift = s.data_out;
                        next_s.bit_count = 4'h0;
                        next_s.engine = twi_pkg::st_low;
                    end
                end
                twi_pkg::st_low:
                begin
                    if (s.bit_count < 4'h8)
                        next_s.drive_sda_low = tx & ~s.shift[7];
                    else
                        next_s.drive_sda_low = ~tx & ~s.control[twi_pkg::ctl_ack_disable];
                    next_s.drive_scl_low = 1'b0;
                    next_s.engine = twi_pkg::st_high;
                end
                twi_pkg::st_high:
                begin
                    // clock stretching: wait for the wire to go high
                    if (bus.scl)
                    begin
                        next_s.drive_scl_low = 1'b1;
                        // lost arbitration, release sda, no stop
                        if (tx && s.bit_count < 4'h8 && s.shift[7] && !bus.sda)
                        begin
                            next_s.status[twi_pkg::st_arbitration_lost] = 1'b1;
                            next_s.drive_sda_low = 1'b0;
                            next_s.drive_scl_low = 1'b0;
                            next_s.master_active = 1'b0;
                            next_s.control[twi_pkg::ctl_master_select] = 1'b0;
                            next_s.control[twi_pkg::ctl_direction_transmit] = 1'b0;
                            next_s.master_prev = 1'b0;
                            next_s.engine = twi_pkg::st_idle;
                            next_s.status[twi_pkg::st_interrupt_pending] = 1'b1;
                        end
                        else if (s.bit_count == 4'h8)
                        begin
                            if (tx)
                                next_s.status[twi_pkg::st_ack_not_received] = bus.sda;
                            else
                                next_s.data_in = s.shift;
                            next_s.drive_sda_low = 1'b0;
                            byte_done = 1'b1;
                            next_s.engine = twi_pkg::st_wait;
                        end
                        else
                        begin
                            next_s.shift = {s.shift[6:0], bus.sda};
                            next_s.bit_count = s.bit_count + 4'h1;
                            next_s.engine = twi_pkg::st_low;
                        end
                    end
                end
                twi_pkg::st_rstrt:
                begin
                    next_s.drive_sda_low = 1'b1;
                    next_s.engine = twi_pkg::st_start;
                end
                twi_pkg::st_stop:
                begin
                    next_s.drive_sda_low = 1'b0;
                    next_s.master_active = 1'b0;
                    next_s.engine = twi_pkg::st_idle;
                end
                default:
                    next_s.engine = twi_pkg::st_idle;
            endcase
        end

        // slave listens only from a start
        if (start_seen && !s.master_active)
        begin
            next_s.slave_active = 1'b1;
            next_s.slave_addr_phase = 1'b1;
            next_s.bit_count = 4'h0;
        end
        else if (stop_seen)
        begin
            next_s.slave_active = 1'b0;
        end
        else if (s.slave_active && !s.master_active && scl_rise)
        begin
            if (s.bit_count < 4'h8)
            begin
                next_s.shift = {s.shift[6:0], bus.sda};
                next_s.bit_count = s.bit_count + 4'h1;
            end
            else
            begin
                next_s.bit_count = 4'h0;
                next_s.slave_addr_phase = 1'b0;
                next_s.ninth_done = 1'b1;
            end
        end
        else if (s.slave_active && !s.master_active && scl_fall)
        begin
            if (s.slave_addr_phase && s.bit_count == 4'h8 && s.shift[7:1] == s.own_address[7:1])
            begin
                next_s.status[twi_pkg::st_addressed_as_slave] = 1'b1;
                next_s.status[twi_pkg::st_slave_read_request] = s.shift[0];
                next_s.slave_ack = 1'b1;
                next_s.status[twi_pkg::st_interrupt_pending] = 1'b1;
            end
            else if (s.ninth_done)
            begin
                next_s.slave_ack = 1'b0;
                next_s.ninth_done = 1'b0;
                if (s.status[twi_pkg::st_addressed_as_slave] || s.slave_ack)
                    byte_done = 1'b1;
            end
        end

        if (byte_done)
        begin
            next_s.status[twi_pkg::st_transfer_complete] = 1'b1;
            next_s.status[twi_pkg::st_interrupt_pending] = 1'b1;
        end

        ////////////////////////////////////////////////////////////
        // axi4-lite slave
        next_s.aw_held = s.aw_held | awvalid;
        if (awvalid && !s.aw_held)
            next_s.aw_index = awaddr[6:2];
        next_s.w_held = s.w_held | wvalid;
        if (wvalid && !s.w_held)
            next_s.w_data = wstrb[0] ? wdata[7:0] : 8'h00;
        if (s.bvalid && bready)
            next_s.bvalid = 1'b0;
        if (wr_go)
        begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = twi_pkg::resp_okay;
            case (s.aw_index)
                twi_pkg::idx_own_slave_address: next_s.own_address = {wv[7:1], 1'b0};
                twi_pkg::idx_bit_rate_divider_select: next_s.rate = wv[4:0];
                twi_pkg::idx_bus_interface_control:
                begin
                    next_s.control = wv & twi_pkg::ctl_implemented_mask &
                        (enabled ? 8'hff : 8'h80);
                    // control write clears addressed; a same-cycle match survives only when the flag was clear before
                    next_s.status[twi_pkg::st_addressed_as_slave] = next_s.status[twi_pkg::st_addressed_as_slave] &
                        ~s.status[twi_pkg::st_addressed_as_slave];
                    // a fresh rise counts even if the fall fell between samples
                    if (next_s.control[twi_pkg::ctl_master_select] && !s.control[twi_pkg::ctl_master_select])
                        next_s.master_prev = 1'b0;
                end
                twi_pkg::idx_bus_interface_status:
                begin
                    // only bits 4 and 1 clearable
                    // zero clears, set wins over clear
                    if (!wv[twi_pkg::st_arbitration_lost] && !next_s.status[twi_pkg::st_arbitration_lost])
                        next_s.status[twi_pkg::st_arbitration_lost] = 1'b0;
                    if (!wv[twi_pkg::st_arbitration_lost] && !(s.status[twi_pkg::st_arbitration_lost] ^
                        next_s.status[twi_pkg::st_arbitration_lost]))
                        next_s.status[twi_pkg::st_arbitration_lost] = 1'b0;
                    if (!wv[twi_pkg::st_interrupt_pending] && !(s.status[twi_pkg::st_interrupt_pending] ^
                        next_s.status[twi_pkg::st_interrupt_pending]))
                        next_s.status[twi_pkg::st_interrupt_pending] = 1'b0;
                end
                twi_pkg::idx_transfer_data:
                begin
                    next_s.data_out = wv;
                    if (tx && !byte_done)
                        next_s.status[twi_pkg::st_transfer_complete] = 1'b0;
                end
                default: next_s.bresp = twi_pkg::resp_slverr;
            endcase
        end

        if (s.rvalid && rready)
            next_s.rvalid = 1'b0;
        if (rd_go)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = twi_pkg::resp_okay;
            case (rd_index)
                twi_pkg::idx_own_slave_address: rv = s.own_address;
                twi_pkg::idx_bit_rate_divider_select: rv = {3'h0, s.rate};
                twi_pkg::idx_bus_interface_control: rv = s.control;
                twi_pkg::idx_bus_interface_status: rv = s.status & 8'hf7;
                twi_pkg::idx_transfer_data:
                begin
                    rv = s.data_in;
                    if (!tx && !byte_done)
                        next_s.status[twi_pkg::st_transfer_complete] = 1'b0;
                end
                default: next_s.rresp = twi_pkg::resp_slverr;
            endcase
            next_s.rdata = {24'h000000, rv};
        end

        // disabled interface logic held in reset
        if (!next_s.control[twi_pkg::ctl_interface_enable])
        begin
            next_s.engine = twi_pkg::st_idle;
            next_s.master_active = 1'b0;
            next_s.drive_scl_low = 1'b0;
            next_s.drive_sda_low = 1'b0;
            next_s.slave_active = 1'b0;
            next_s.slave_ack = 1'b0;
            next_s.ninth_done = 1'b0;
            next_s.master_prev = 1'b0;
            next_s.status = twi_pkg::status_reset;
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.scl_sync <= 2'h3;
            s.sda_sync <= 2'h3;
            s.scl_prev <= 1'b1;
            s.sda_prev <= 1'b1;
            s.rate <= twi_pkg::rate_reset;
            s.control <= twi_pkg::control_reset;
            s.status <= twi_pkg::status_reset;
            s.engine <= twi_pkg::st_idle;
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs
    assign awready = ~s.aw_held;
    assign wready = ~s.w_held;
    assign arready = ~s.rvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = ~s.drive_scl_low;
    // slave ack pulls sda during the ninth bit
    assign sda_oe_n = ~(s.drive_sda_low | s.slave_ack);
    assign irq = s.status[twi_pkg::st_interrupt_pending] & s.control[twi_pkg::ctl_interrupt_enable];

endmodule

// [pkg/twi_pkg.sv]
package twi_pkg;

    // register offsets; printed offsets are not word multiples, so they are indices
    localparam logic [4:0] idx_own_slave_address = 5'h10;
    localparam logic [4:0] idx_bit_rate_divider_select = 5'h11;
    localparam logic [4:0] idx_bus_interface_control = 5'h12;
    localparam logic [4:0] idx_bus_interface_status = 5'h13;
    localparam logic [4:0] idx_transfer_data = 5'h14;

    // control field positions
    localparam int ctl_interface_enable = 7;
    localparam int ctl_interrupt_enable = 6;
    localparam int ctl_master_select = 5;
    localparam int ctl_direction_transmit = 4;
    localparam int ctl_ack_disable = 3;
    localparam logic [7:0] ctl_implemented_mask = 8'hf8;

    // status field positions
    localparam int st_transfer_complete = 7;
    localparam int st_addressed_as_slave = 6;
    localparam int st_bus_busy_flag = 5;
    localparam int st_arbitration_lost = 4;
    localparam int st_slave_read_request = 2;
    localparam int st_interrupt_pending = 1;
    localparam int st_ack_not_received = 0;

    // reset values
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [4:0] rate_reset = 5'h00;
    localparam logic [7:0] status_reset = 8'h81;

    // sampling overhead per scl period, in cpu clocks
    localparam logic [12:0] sample_overhead = 13'h0006;

    // axi responses
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    // bit engine states
    typedef enum logic [6:0] {
        st_idle  = 7'h01,
        st_start = 7'h02,
        st_low   = 7'h04,
        st_high  = 7'h08,
        st_rstrt = 7'h10,
        st_stop  = 7'h20,
        st_wait  = 7'h40
    } engine_t;

    typedef struct packed {
        logic       scl;
        logic       sda;
    } pins_t;

    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic       scl_prev;
        logic       sda_prev;
        logic [7:0] own_address;
        logic [4:0] rate;
        logic [7:0] control;
        logic [7:0] status;
        logic [7:0] data_out;
        logic [7:0] data_in;
        logic [7:0] shift;
        logic [3:0] bit_count;
        logic [12:0] divider;
        logic [12:0] tick_count;
        logic       sample;
        engine_t    engine;
        logic       master_active;
        logic       drive_scl_low;
        logic       drive_sda_low;
        logic       slave_active;
        logic       slave_addr_phase;
        logic       slave_ack;
        logic       ninth_done;
        logic       master_prev;
        logic       aw_held;
        logic [4:0] aw_index;
        logic       w_held;
        logic [7:0] w_data;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

endpackage

// [verification/twi_checker.sv]
`timescale 1ns/10ps
module twi_checker
(
    // clock, reset and register bus
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // bus pins and request
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////
    // reset must free both wires, not only stop the engine
    AST_RESET_IDLE: assert property (disable iff (1'b0)
        !aresetn |=> scl_oe_n && sda_oe_n && !irq && !bvalid && !rvalid) else $error("active after reset");
    // write answer follows both channels within a short bound
    AST_W_ANSWER: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:3] bvalid) else $error("write not answered");
    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
    AST_B_DONE: assert property (
        bvalid && bready |=> !bvalid) else $error("write response repeated");
    // status stays readable: every read is answered next cycle
    AST_R_ANSWER: assert property (
        arvalid && arready |=> rvalid) else $error("read not answered");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
    AST_R_DONE: assert property (
        rvalid && rready |=> !rvalid) else $error("read data repeated");
    AST_AR_BLOCK: assert property (
        rvalid |-> !arready) else $error("second read taken");
    // registers are eight bits; upper lanes read zero
    AST_RDATA_WIDTH: assert property (
        rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind two_wire_bus_control_status twi_checker chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .scl_oe_n, .sda_oe_n, .irq);

// [verification/bus_peer_model.sv]
`timescale 1ns/10ps
module bus_peer_model
(
    // clock and resolved wires
    input wire logic aclk,
    input wire logic scl,
    input wire logic sda,
    // another master holding the data line low
    input wire logic hold_low,
    // low while pulling the data line
    output logic sda_n
);
    logic ps = 1'b1;
    logic pd = 1'b1;
    logic [3:0] cnt = 4'h0;
    logic ack = 1'b0;
    assign sda_n = !(ack || hold_low);
    // slave that acknowledges every byte; counts scl falls after a start
    always @(posedge aclk)
    begin
        ps <= scl;
        pd <= sda;
        if (scl && ps && pd && !sda)
            cnt <= 4'h0;
        else if (ps && !scl)
        begin
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            ack <= (cnt == 4'h8);
        end
    end
endmodule

// [verification/two_wire_bus_control_status_tb.sv]
`timescale 1ns/10ps
module two_wire_bus_control_status_tb;
    localparam logic [4:0] ix_rate = twi_pkg::idx_bit_rate_divider_select;
    localparam logic [4:0] ix_ctl = twi_pkg::idx_bus_interface_control;
    localparam logic [4:0] ix_st = twi_pkg::idx_bus_interface_status;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, irq, peer_n, hold = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    int errors = 0, compares = 0, cyc = 0;
    // open drain with pull-ups: a wire is low if any party pulls
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & peer_n;
    two_wire_bus_control_status DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .scl_in(scl), .scl_out(), .scl_oe_n, .sda_in(sda), .sda_out(),
        .sda_oe_n, .irq);
    bus_peer_model peer (.aclk, .scl, .sda, .hold_low(hold), .sda_n(peer_n));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        forever #25 aclk = ~aclk;
    end
    // hang guard; the longest poll sequence stays far below it
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // ready sampled at the falling edge, released after the taking edge
    task automatic wr(input logic [4:0] i, input logic [7:0] v);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= {1'b0, i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] i);
        logic ta, tr;
        @(posedge aclk);
        araddr <= {1'b0, i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    // bounded wait on one status bit
    task automatic poll(input int b, input logic v);
        for (int k = 0; k < 300; k++)
        begin
            rd(ix_st);
            if (d[b] === v)
                break;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ix_rate); chk("rate", d, 32'h0);
        rd(ix_ctl); chk("control", d, 32'h0);
        rd(ix_st); chk("status", d, 32'h81);
        wr(ix_ctl, 8'h78); rd(ix_ctl); chk("control", d, 32'h0);
        wr(ix_rate, 8'h1f); rd(ix_rate); chk("rate", d, 32'h1f);
        wr(ix_rate, 8'h00);
        wr(5'h18, 8'h5a); chk("bresp", r, 32'h2);
        rd(5'h18); chk("rresp", r, 32'h2);
        wr(ix_ctl, 8'h80); wr(ix_ctl, 8'hcf); rd(ix_ctl); chk("control", d, 32'hc8);
        wr(ix_st, 8'h00); rd(ix_st); chk("status", d, 32'h81);
        // another master starts, then stops
        hold <= 1'b1; poll(5, 1'b1); chk("busy", d, 32'ha1);
        hold <= 1'b0; poll(5, 1'b0); chk("idle", d, 32'h81);
        // master sends one acknowledged byte
        wr(ix_ctl, 8'hf0); wr(5'h14, 8'ha4); poll(1, 1'b1); chk("status", d, 32'ha2);
        chk("irq", irq, 1'b1);
        wr(ix_st, 8'h00); rd(ix_st); chk("status", d, 32'ha0);
        chk("irq", irq, 1'b0);
        wr(ix_ctl, 8'h90); poll(5, 1'b0); chk("status", d, 32'h80);
        chk("lines", {scl_oe_n, sda_oe_n}, 32'h3);
        conclude();
    end
endmodule
